// ===== epe_pkg.sv
// Summary of operation
// - Coarse resolution sets the quadrature increments per revolution (fourfold A/B edges), 8 to 65535, default 4096.
// - One index pulse per revolution is emitted inside an interval where both A and B are high.
// - Fine resolution gives increments per revolution as unsigned fixed point with 12 fractional bits.
// - Coarse resolution is used only while fine resolution is 0, otherwise fine resolution governs.
// - A fine resolution that is a multiple of 4096 keeps the index at a fixed angle, otherwise it drifts.
// - A signed phase offset in 1/4096 increment steps shifts the pulses at once, without restart.
// - The index pulse moves by the same phase offset as the A/B signals.
// - Resolution changes are accepted only with the power stage off and apply at the next restart.
package epe_pkg;

  // Register offsets on the parameter port
  localparam logic [15:0] EPE_ADDR_COARSE = 16'h052a;
  localparam logic [15:0] EPE_ADDR_FINE   = 16'h0564;
  localparam logic [15:0] EPE_ADDR_PHASE  = 16'h0566;

  // Values after reset and legal limits
  localparam logic [15:0] EPE_COARSE_RST = 16'h1000;
  localparam logic [31:0] EPE_FINE_RST   = 32'h0000_0000;
  localparam logic [15:0] EPE_PHASE_RST  = 16'h0000;
  localparam logic [15:0] EPE_COARSE_MIN = 16'h0008;
  localparam logic [31:0] EPE_FINE_MAX   = 32'h0fff_f000;

  // Field positions and counts
  localparam int EPE_FRAC_BITS = 12;
  localparam int EPE_REV_BITS  = 16;
  localparam logic [31:0] EPE_IDX_WIN = 32'h0000_0004;

  // Start-up sequence after power-on or restart
  typedef enum logic [1:0] {
    EPE_ST_CAPTURE = 2'b00,
    EPE_ST_TARGET  = 2'b01,
    EPE_ST_LOAD    = 2'b10,
    EPE_ST_RUN     = 2'b11
  } epe_state_t;

endpackage

// ===== epe_step_if.sv
`timescale 1ns/1ps
// Link between the position control and the quadrature step generator
interface epe_step_if #(parameter int CNT_W = 32);
  logic signed [CNT_W-1:0] target;
  logic                    load;
  logic                    step;
  logic                    dir;
  logic [1:0]              quad;

  modport ctl (output target, output load, input step, input dir, input quad);
  modport gen (input target, input load, output step, output dir, output quad);
endinterface

// ===== epe_quad_gen.sv
`timescale 1ns/1ps
module epe_quad_gen
  import epe_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic core_clk,
  input wire logic rst_sync_b,
  epe_step_if.gen  sif
);

  logic signed [CNT_W-1:0] count_q;
  logic                    step_q;
  logic                    dir_q;

  // One increment per clock toward the target, so outside a load a jump never skips a state
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      count_q <= '0;
      step_q  <= 1'b0;
      dir_q   <= 1'b0;
    end else if (sif.load) begin
      count_q <= sif.target;
      step_q  <= 1'b0;
      dir_q   <= 1'b0;
    end else if (count_q < sif.target) begin
      count_q <= count_q + 1'b1;
      step_q  <= 1'b1;
      dir_q   <= 1'b1;
    end else if (count_q > sif.target) begin
      count_q <= count_q - 1'b1;
      step_q  <= 1'b1;
      dir_q   <= 1'b0;
    end else begin
      step_q  <= 1'b0;
    end
  end

  assign sif.step = step_q;
  assign sif.dir  = dir_q;
  assign sif.quad = count_q[1:0];

endmodule

// ===== epe_encoder_pulse_emulator.sv
`timescale 1ns/1ps
module epe_encoder_pulse_emulator
  import epe_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [31:0] motor_pos,
  input  wire logic        power_stage_en,
  input  wire logic        restart,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             pto_a,
  output logic             pto_b,
  output logic             pto_index
);

  logic        rst_s1_q;
  logic        rst_sync_b;
  logic [15:0] coarse_q;
  logic [31:0] fine_q;
  logic [15:0] phase_q;
  logic [31:0] res_act_q;
  logic [31:0] rev_len_q;
  logic [31:0] idx_pos_q;
  logic [31:0] rdata_q;
  logic        a_q;
  logic        b_q;
  logic        index_q;
  logic [1:0]  quad_q;
  logic signed [CNT_W-1:0] target_q;
  epe_state_t  state_q;

  epe_step_if #(.CNT_W(CNT_W)) sif ();

  // Quadrature phase coding: A leads B when the count rises
  function automatic logic quad_a(input logic [1:0] c);
    return c[1] ^ c[0];
  endfunction

  function automatic logic quad_b(input logic [1:0] c);
    return c[1];
  endfunction

  // Resolution writes pass only with the power stage off; the new value waits
  // for the next restart, so a running axis sees its scale change only at a restart
  function automatic logic res_wr_ok(input logic        wr,
                                     input logic [15:0] addr,
                                     input logic [15:0] slot,
                                     input logic        pwr_on);
    return wr && addr == slot && !pwr_on;
  endfunction

  // Emulated increments from motor angle, active resolution and phase offset
  // Products stay inside 64 bits for every resolution up to the fine maximum
  function automatic logic signed [CNT_W-1:0] calc_target(input logic [31:0] pos,
                                                          input logic [31:0] res,
                                                          input logic [15:0] ph);
    logic signed [63:0] prod;
    logic signed [63:0] fine;
    prod = $signed({{32{pos[31]}}, pos}) * $signed({32'h0000_0000, res});
    fine = (prod >>> EPE_REV_BITS) + $signed({{48{ph[15]}}, ph});
    return CNT_W'(fine >>> EPE_FRAC_BITS);
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_s1_q   <= 1'b1;
      rst_sync_b <= rst_s1_q;
    end
  end

  // Coarse setting; locked while the power stage runs, too small values refused
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      coarse_q <= EPE_COARSE_RST;
    end else if (res_wr_ok(reg_wr, reg_addr, EPE_ADDR_COARSE, power_stage_en) &&
                 reg_wdata[15:0] >= EPE_COARSE_MIN) begin
      coarse_q <= reg_wdata[15:0];
    end
  end

  // Fine setting; same lock, values beyond the fixed-point range refused
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      fine_q <= EPE_FINE_RST;
    end else if (res_wr_ok(reg_wr, reg_addr, EPE_ADDR_FINE, power_stage_en) &&
                 reg_wdata <= EPE_FINE_MAX) begin
      fine_q <= reg_wdata;
    end
  end

  // Phase offset feeds the next target directly, so it needs no restart
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      phase_q <= EPE_PHASE_RST;
    end else if (reg_wr && reg_addr == EPE_ADDR_PHASE) begin
      phase_q <= reg_wdata[15:0];
    end
  end

  // Read data is registered; unmapped offsets read zero
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        EPE_ADDR_COARSE: rdata_q <= {16'h0000, coarse_q};
        EPE_ADDR_FINE:   rdata_q <= fine_q;
        EPE_ADDR_PHASE:  rdata_q <= {16'h0000, phase_q};
        default:         rdata_q <= '0;
      endcase
    end
  end

  // Start-up: capture resolution, settle target, jump generator, then track
  // A restart in motion re-captures at once; the generator follows the old scale until load
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_q <= EPE_ST_CAPTURE;
    end else if (restart) begin
      state_q <= EPE_ST_CAPTURE;
    end else begin
      unique case (state_q)
        EPE_ST_CAPTURE: state_q <= EPE_ST_TARGET;
        EPE_ST_TARGET:  state_q <= EPE_ST_LOAD;
        EPE_ST_LOAD:    state_q <= EPE_ST_RUN;
        EPE_ST_RUN:     state_q <= EPE_ST_RUN;
      endcase
    end
  end

  // Active resolution only changes at power-on or restart, a restart in motion included
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      res_act_q <= '0;
      rev_len_q <= {16'h0000, EPE_COARSE_MIN};
    end else if (state_q == EPE_ST_CAPTURE) begin
      if (fine_q != 32'h0000_0000) begin
        res_act_q <= fine_q;
        rev_len_q <= fine_q >> EPE_FRAC_BITS;
      end else begin
        res_act_q <= {4'h0, coarse_q, 12'h000};
        rev_len_q <= {16'h0000, coarse_q};
      end
    end
  end

  // Target is registered to break the long multiply path; this costs one clock
  // of lag between the shaft and the pulses
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      target_q <= '0;
    end else begin
      target_q <= calc_target(motor_pos, res_act_q, phase_q);
    end
  end

  assign sif.target = target_q;
  assign sif.load   = (state_q == EPE_ST_LOAD);

  epe_quad_gen #(.CNT_W(CNT_W)) i_epe_quad_gen (
    .core_clk   (core_clk),
    .rst_sync_b (rst_sync_b),
    .sif        (sif)
  );

  // Position within the revolution follows the generated increments, so a
  // non-integer resolution lets the index drift by the lost fraction
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      idx_pos_q <= '0;
    end else if (sif.load) begin
      idx_pos_q <= {30'h0, target_q[1:0]};
    end else if (sif.step && sif.dir) begin
      idx_pos_q <= (idx_pos_q >= rev_len_q - 1'b1) ? 32'h0 : idx_pos_q + 1'b1;
    end else if (sif.step) begin
      idx_pos_q <= (idx_pos_q == 32'h0) ? rev_len_q - 1'b1 : idx_pos_q - 1'b1;
    end
  end

  // Delay the phase one cycle to line it up with the index position, which
  // follows the step flag and so lags the count by one clock
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      quad_q <= 2'h0;
    end else begin
      quad_q <= sif.quad;
    end
  end

  // Registered outputs; A, B and index all come from the same delayed phase so
  // a pulse counter never sees the index beside the wrong step
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      a_q     <= 1'b0;
      b_q     <= 1'b0;
      index_q <= 1'b0;
    end else begin
      a_q     <= quad_a(quad_q);
      b_q     <= quad_b(quad_q);
      index_q <= (idx_pos_q < EPE_IDX_WIN) && quad_a(quad_q) && quad_b(quad_q);
    end
  end

  assign reg_rdata = rdata_q;
  assign pto_a     = a_q;
  assign pto_b     = b_q;
  assign pto_index = index_q;

endmodule

// ===== epe_sva.sv
`timescale 1ns/1ps
module epe_sva
  import epe_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        power_stage_en,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        pto_a,
  input wire logic        pto_b,
  input wire logic        pto_index
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Read of an offset outside the table
  logic rd_none;
  assign rd_none = reg_rd && reg_addr != EPE_ADDR_COARSE && reg_addr != EPE_ADDR_FINE
                   && reg_addr != EPE_ADDR_PHASE;
  property p_one_edge; !($changed(pto_a) && $changed(pto_b)); endproperty
  a_one_edge: assert property (p_one_edge) else $error("A and B moved together");
  property p_idx_ab; pto_index |-> pto_a && pto_b; endproperty
  a_idx_ab: assert property (p_idx_ab) else $error("index outside A=B=1");
  property p_coarse_hi; reg_rd && reg_addr == EPE_ADDR_COARSE |=> reg_rdata[31:16] == 16'h0000;
  endproperty
  a_coarse_hi: assert property (p_coarse_hi) else $error("coarse upper bits set");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_unmapped; rd_none |=> reg_rdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_fine_wr;
    reg_wr && reg_addr == EPE_ADDR_FINE && !power_stage_en && reg_wdata <= EPE_FINE_MAX
    ##2 reg_rd && reg_addr == EPE_ADDR_FINE |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_fine_wr: assert property (p_fine_wr) else $error("fine write lost");
  property p_phase_wr;
    reg_wr && reg_addr == EPE_ADDR_PHASE ##2 reg_rd && reg_addr == EPE_ADDR_PHASE
    |=> reg_rdata == {16'h0000, $past(reg_wdata[15:0], 3)};
  endproperty
  a_phase_wr: assert property (p_phase_wr) else $error("phase write lost");
  property p_coarse_min;
    reg_wr && reg_addr == EPE_ADDR_COARSE && reg_wdata[15:0] < EPE_COARSE_MIN
    ##2 reg_rd && reg_addr == EPE_ADDR_COARSE |=> reg_rdata[15:0] >= EPE_COARSE_MIN;
  endproperty
  a_coarse_min: assert property (p_coarse_min) else $error("coarse below minimum");
  // Main traffic seen: index, forward and reverse edges
  c_idx: cover property ($rose(pto_index));
  c_fwd: cover property ($rose(pto_a) && !pto_b);
  c_rev: cover property ($rose(pto_b) && !pto_a);
endmodule
bind epe_encoder_pulse_emulator epe_sva i_epe_sva (.core_clk, .rst_b, .power_stage_en,
  .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .pto_a, .pto_b, .pto_index);

// ===== epe_ctrl_model.sv
`timescale 1ns/1ps
module epe_ctrl_model (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic pto_a,
  input  wire logic pto_b,
  input  wire logic pto_index,
  output int        pos_cnt,
  output int        idx_cnt
);
  logic [1:0] ph_q;
  logic       idx_q;
  // Fourfold decode; a two-phase jump is ambiguous and is not counted
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_cnt <= 0;
      idx_cnt <= 0;
      ph_q <= 2'h0;
      idx_q <= 1'b0;
    end else begin
      ph_q <= {pto_b, pto_a ^ pto_b};
      idx_q <= pto_index;
      if ({pto_b, pto_a ^ pto_b} - ph_q == 2'h1) pos_cnt <= pos_cnt + 1;
      if ({pto_b, pto_a ^ pto_b} - ph_q == 2'h3) pos_cnt <= pos_cnt - 1;
      if (pto_index && !idx_q) idx_cnt <= idx_cnt + 1;
    end
  end
endmodule

// ===== epe_encoder_pulse_emulator_tb.sv
`timescale 1ns/1ps
module epe_encoder_pulse_emulator_tb import epe_pkg::*;;
  typedef struct {logic [15:0] a; logic [31:0] d; logic [31:0] e;} epe_row_t;
  logic core_clk = 1'b0, rst_b = 1'b0, power_stage_en = 1'b0, restart = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, pto_a, pto_b, pto_index;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] motor_pos = 32'h0, reg_wdata = 32'h0, reg_rdata;
  int pos_cnt, idx_cnt, c0, i0, miscompares = 0, n_tests = 0, n_cyc = 0;
  // Write then read back; refused writes leave the earlier value
  epe_row_t rows [11] = '{'{EPE_ADDR_PHASE, 32'hffff_8000, 32'h0000_8000},
    '{EPE_ADDR_PHASE, 32'h0000_7fff, 32'h0000_7fff}, '{EPE_ADDR_COARSE, 32'h8, 32'h8},
    '{EPE_ADDR_COARSE, 32'h7, 32'h8}, '{EPE_ADDR_COARSE, 32'hffff, 32'hffff},
    '{EPE_ADDR_FINE, 32'h0fff_f000, 32'h0fff_f000}, '{EPE_ADDR_FINE, 32'h0fff_f001, 32'h0fff_f000},
    '{EPE_ADDR_FINE, 32'h0, 32'h0}, '{EPE_ADDR_COARSE, 32'h40, 32'h40},
    '{16'h0000, 32'h1, 32'h0}, '{EPE_ADDR_PHASE, 32'h0, 32'h0}};
  epe_encoder_pulse_emulator i_epe_encoder_pulse_emulator (.core_clk, .rst_b, .motor_pos,
    .power_stage_en, .restart, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .pto_a,
    .pto_b, .pto_index);
  epe_ctrl_model i_epe_ctrl_model (.core_clk, .rst_b, .pto_a, .pto_b, .pto_index, .pos_cnt,
    .idx_cnt);
  always #50 core_clk = ~core_clk;
  task automatic give_verdict();
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [31:0] e);
    @(posedge core_clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk) reg_rd <= 1'b0;
    @(negedge core_clk) chk(nm, reg_rdata, e);
  endtask
  // Let earlier moves settle, turn the shaft, then give the generator time to catch up
  task automatic spin(input int n, input logic [31:0] st);
    repeat (30) @(posedge core_clk);
    c0 = pos_cnt;
    i0 = idx_cnt;
    repeat (n) @(posedge core_clk) motor_pos <= motor_pos + st;
    repeat (30) @(posedge core_clk);
  endtask
  task automatic warm();
    @(posedge core_clk) restart <= 1'b1;
    @(posedge core_clk) restart <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask
  // Hang guard, well above the expected run of about 1220 cycles
  always @(posedge core_clk) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd_chk("coarse_rst", EPE_ADDR_COARSE, 32'h0000_1000);
    rd_chk("fine_rst", EPE_ADDR_FINE, 32'h0);
    rd_chk("phase_rst", EPE_ADDR_PHASE, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd_chk("row", rows[i].a, rows[i].e);
    end
    @(posedge core_clk) power_stage_en <= 1'b1;
    wr(EPE_ADDR_COARSE, 32'h0000_0100);
    rd_chk("coarse_locked", EPE_ADDR_COARSE, 32'h40);
    @(posedge core_clk) power_stage_en <= 1'b0;
    spin(64, 32'h10);
    chk("old_res", pos_cnt - c0, 32'd64);
    warm();
    spin(256, 32'h100);
    chk("fwd_rev", pos_cnt - c0, 32'd64);
    chk("fwd_idx", idx_cnt - i0, 32'd1);
    spin(256, 32'hffff_ff00);
    chk("back_rev", pos_cnt - c0, 32'hffff_ffc0);
    chk("back_idx", idx_cnt - i0, 32'd1);
    wr(EPE_ADDR_FINE, 32'h0002_0000);
    warm();
    spin(256, 32'h100);
    chk("fine_rev", pos_cnt - c0, 32'd32);
    chk("fine_idx", idx_cnt - i0, 32'd1);
    c0 = pos_cnt;
    wr(EPE_ADDR_PHASE, 32'h0000_4000);
    repeat (30) @(posedge core_clk);
    chk("phase_move", pos_cnt - c0, 32'd4);
    // Reset in mid-run brings the settings back to their power-on values
    @(posedge core_clk) rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd_chk("coarse_rst2", EPE_ADDR_COARSE, 32'h0000_1000);
    rd_chk("fine_rst2", EPE_ADDR_FINE, 32'h0);
    rd_chk("phase_rst2", EPE_ADDR_PHASE, 32'h0);
    give_verdict();
  end
endmodule
